// >>> common/psh_pkg.sv
// Shared constants and carrier types for the peripheral register shell
package psh_pkg;
	localparam int NPORT     = 2;
	localparam int DW        = 32;
	localparam int PTR_W     = 32;
	localparam int CNT_W     = 16;
	localparam int CHAR_W    = 8;
	localparam int FIFO_D    = 8;
	localparam int WIN_BITS  = 14;
	localparam int IRQC_BITS = 12;
	localparam int PIDX_W    = $clog2(NPORT);
	localparam int AW        = WIN_BITS + PIDX_W;

	// Byte offsets inside one port window
	localparam logic [WIN_BITS-1:0] OFF_CTRL   = 14'h0000;
	localparam logic [WIN_BITS-1:0] OFF_MODE   = 14'h0004;
	localparam logic [WIN_BITS-1:0] OFF_CH_SET = 14'h0008;
	localparam logic [WIN_BITS-1:0] OFF_CH_CLR = 14'h000C;
	localparam logic [WIN_BITS-1:0] OFF_CH_ST  = 14'h0010;
	localparam logic [WIN_BITS-1:0] OFF_STATUS = 14'h0014;
	localparam logic [WIN_BITS-1:0] OFF_IEN    = 14'h0018;
	localparam logic [WIN_BITS-1:0] OFF_IDIS   = 14'h001C;
	localparam logic [WIN_BITS-1:0] OFF_IMASK  = 14'h0020;
	localparam logic [WIN_BITS-1:0] OFF_RX_PTR = 14'h0030;
	localparam logic [WIN_BITS-1:0] OFF_RX_CNT = 14'h0034;
	localparam logic [WIN_BITS-1:0] OFF_TX_PTR = 14'h0038;
	localparam logic [WIN_BITS-1:0] OFF_TX_CNT = 14'h003C;

	// Field positions and widths
	localparam int CTRL_CLR_ERR = 0;
	localparam int MODE_W       = 1;
	localparam int MODE_FIXED   = 0;
	localparam int CH_W         = 2;
	localparam int CH_RX        = 0;
	localparam int CH_TX        = 1;
	localparam int ST_W         = 4;
	localparam int ST_RX_END    = 0;
	localparam int ST_TX_END    = 1;
	localparam int ST_RX_RDY    = 2;
	localparam int ST_OVERRUN   = 3;

	// Values after reset and per-transfer pointer and count steps
	localparam logic [MODE_W-1:0] MODE_RST = 1'h0;
	localparam logic [CH_W-1:0]   CH_RST   = 2'h0;
	localparam logic [ST_W-1:0]   MASK_RST = 4'h0;
	localparam logic [PTR_W-1:0]  PTR_RST  = 32'h0000_0000;
	localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
	localparam logic [DW-1:0]     RDATA_RST = 32'h0000_0000;
	localparam logic [PTR_W-1:0]  PTR_STEP = 32'h0000_0001;
	localparam logic [CNT_W-1:0]  CNT_STEP = 16'h0001;

	typedef struct packed {
		logic          sel;
		logic          enable;
		logic          write;
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
	} psh_bus_req_t;

	typedef struct packed {
		logic              valid;
		logic [PTR_W-1:0]  addr;
		logic [CHAR_W-1:0] data;
	} psh_wr_req_t;

	typedef struct packed {
		logic             valid;
		logic [PTR_W-1:0] addr;
	} psh_rd_req_t;

	typedef struct packed {
		logic [MODE_W-1:0] mode;
		logic [CH_W-1:0]   chen;
		logic [ST_W-1:0]   imask;
		logic              overrun;
		logic [PTR_W-1:0]  rx_ptr;
		logic [CNT_W-1:0]  rx_cnt;
		logic [PTR_W-1:0]  tx_ptr;
		logic [CNT_W-1:0]  tx_cnt;
	} psh_port_t;
endpackage : psh_pkg

// >>> rtl/psh_fifo.sv
// Parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/100ps
module psh_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int PW = (D > 1) ? $clog2(D) : 1;
	localparam int CW = $clog2(D + 1);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [PW-1:0]       wp;
		logic [PW-1:0]       rp;
		logic [CW-1:0]       cnt;
	} psh_fifo_state_t;

	psh_fifo_state_t s_reg;
	psh_fifo_state_t s_next;
	logic            push;
	logic            pop;

	assign in_ready  = (s_reg.cnt != CW'(D));
	assign out_valid = (s_reg.cnt != '0);
	assign out_data  = s_reg.mem[s_reg.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		s_next = s_reg;
		if (push) begin
			s_next.mem[s_reg.wp] = in_data;
			s_next.wp = (s_reg.wp == PW'(D - 1)) ? '0 : s_reg.wp + PW'(1);
		end
		if (pop) begin
			s_next.rp = (s_reg.rp == PW'(D - 1)) ? '0 : s_reg.rp + PW'(1);
		end
		if (push && !pop) begin
			s_next.cnt = s_reg.cnt + CW'(1);
		end else if (pop && !push) begin
			s_next.cnt = s_reg.cnt - CW'(1);
		end
		if (!rst_n) begin
			s_next.wp  = '0;
			s_next.rp  = '0;
			s_next.cnt = '0;
		end
	end

	always_ff @(posedge clock) begin
		s_reg <= s_next;
	end
endmodule : psh_fifo

// >>> rtl/psh_shell.sv
// Register shell, transfer channels and interrupt sources of the serial ports
`timescale 1ns/100ps
module psh_shell #(
	parameter int NPORT  = psh_pkg::NPORT,
	parameter int CHAR_W = psh_pkg::CHAR_W,
	parameter int FIFO_D = psh_pkg::FIFO_D
) (
	input  wire logic                              clock,
	input  wire logic                              rst_n,
	input  wire psh_pkg::psh_bus_req_t             bus_req,
	output logic [psh_pkg::DW-1:0]                 bus_rdata,
	input  wire logic [NPORT-1:0]                  rx_in_valid,
	output logic [NPORT-1:0]                       rx_in_ready,
	input  wire logic [NPORT-1:0][CHAR_W-1:0]      rx_in_data,
	output psh_pkg::psh_wr_req_t [NPORT-1:0]       rx_wr,
	input  wire logic [NPORT-1:0]                  rx_wr_ready,
	output psh_pkg::psh_rd_req_t [NPORT-1:0]       tx_rd,
	input  wire logic [NPORT-1:0]                  tx_rd_ready,
	output logic [NPORT-1:0]                       irq
);
	typedef struct packed {
		psh_pkg::psh_port_t [NPORT-1:0] port;
		logic [psh_pkg::DW-1:0]         rdata;
	} psh_shell_state_t;

	psh_shell_state_t                         s_reg;
	psh_shell_state_t                         s_next;
	logic [NPORT-1:0]                         fifo_out_valid;
	logic [NPORT-1:0]                         fifo_out_ready;
	logic [NPORT-1:0][CHAR_W-1:0]             fifo_out_data;
	logic [NPORT-1:0][psh_pkg::ST_W-1:0]      status;
	logic [NPORT-1:0]                         rx_go;
	logic [NPORT-1:0]                         tx_go;
	logic                                     bus_wr;
	logic                                     bus_rd;
	logic [psh_pkg::WIN_BITS-1:0]             bus_off;
	logic [psh_pkg::PIDX_W-1:0]               bus_port;

	// True when the access offset names the given register
	function automatic logic hit(
		input logic [psh_pkg::WIN_BITS-1:0] off,
		input logic [psh_pkg::WIN_BITS-1:0] reg_off
	);
		hit = (off == reg_off);
	endfunction : hit

	// Live status word of one port
	function automatic logic [psh_pkg::ST_W-1:0] port_status(
		input psh_pkg::psh_port_t p,
		input logic               rx_rdy
	);
		logic [psh_pkg::ST_W-1:0] st;
		st = '0;
		st[psh_pkg::ST_RX_END]  = (p.rx_cnt == psh_pkg::CNT_RST);
		st[psh_pkg::ST_TX_END]  = (p.tx_cnt == psh_pkg::CNT_RST);
		st[psh_pkg::ST_RX_RDY]  = rx_rdy;
		st[psh_pkg::ST_OVERRUN] = p.overrun;
		port_status = st;
	endfunction : port_status

	// Byte and half-word accesses fall onto the enclosing word
	assign bus_off  = {bus_req.addr[psh_pkg::WIN_BITS-1:2], 2'b00};
	assign bus_port = bus_req.addr[psh_pkg::AW-1:psh_pkg::WIN_BITS];
	assign bus_wr   = bus_req.sel && bus_req.enable && bus_req.write;
	assign bus_rd   = bus_req.sel && !bus_req.enable && !bus_req.write;

	genvar g;
	generate
		for (g = 0; g < NPORT; g++) begin : g_port
			psh_fifo #(
				.W (CHAR_W),
				.D (FIFO_D)
			) u_rx_fifo (
				.clock     (clock),
				.rst_n     (rst_n),
				.in_valid  (rx_in_valid[g]),
				.in_ready  (rx_in_ready[g]),
				.in_data   (rx_in_data[g]),
				.out_valid (fifo_out_valid[g]),
				.out_ready (fifo_out_ready[g]),
				.out_data  (fifo_out_data[g])
			);

			assign status[g] = port_status(s_reg.port[g], fifo_out_valid[g]);
			// A channel runs only while enabled and count is nonzero
			assign rx_go[g]  = s_reg.port[g].chen[psh_pkg::CH_RX]
				&& (s_reg.port[g].rx_cnt != psh_pkg::CNT_RST) && fifo_out_valid[g];
			assign tx_go[g]  = s_reg.port[g].chen[psh_pkg::CH_TX]
				&& (s_reg.port[g].tx_cnt != psh_pkg::CNT_RST);
			assign fifo_out_ready[g] = rx_go[g] && rx_wr_ready[g];

			assign rx_wr[g].valid = rx_go[g];
			assign rx_wr[g].addr  = s_reg.port[g].rx_ptr;
			assign rx_wr[g].data  = fifo_out_data[g];
			assign tx_rd[g].valid = tx_go[g];
			assign tx_rd[g].addr  = s_reg.port[g].tx_ptr;

			assign irq[g] = |(status[g] & s_reg.port[g].imask);
		end
	endgenerate

	assign bus_rdata = s_reg.rdata;

	always_comb begin
		logic [psh_pkg::PTR_W-1:0] step;
		logic                      sel_p;
		s_next = s_reg;
		step   = '0;
		sel_p  = 1'b0;
		for (int p = 0; p < NPORT; p++) begin
			step  = s_reg.port[p].mode[psh_pkg::MODE_FIXED] ? '0 : psh_pkg::PTR_STEP;
			sel_p = (32'(bus_port) == p);

			// Channel progress
			if (rx_go[p] && rx_wr_ready[p]) begin
				s_next.port[p].rx_ptr = s_reg.port[p].rx_ptr + step;
				s_next.port[p].rx_cnt = s_reg.port[p].rx_cnt - psh_pkg::CNT_STEP;
			end
			if (tx_go[p] && tx_rd_ready[p]) begin
				s_next.port[p].tx_ptr = s_reg.port[p].tx_ptr + step;
				s_next.port[p].tx_cnt = s_reg.port[p].tx_cnt - psh_pkg::CNT_STEP;
			end

			// Software writes; a pointer write overrides same-cycle progress
			if (bus_wr && sel_p) begin
				if (hit(bus_off, psh_pkg::OFF_CTRL) && bus_req.wdata[psh_pkg::CTRL_CLR_ERR]) begin
					s_next.port[p].overrun = 1'b0;
				end
				if (hit(bus_off, psh_pkg::OFF_MODE)) begin
					s_next.port[p].mode = bus_req.wdata[psh_pkg::MODE_W-1:0];
				end
				if (hit(bus_off, psh_pkg::OFF_CH_SET)) begin
					s_next.port[p].chen = s_reg.port[p].chen | bus_req.wdata[psh_pkg::CH_W-1:0];
				end
				if (hit(bus_off, psh_pkg::OFF_CH_CLR)) begin
					s_next.port[p].chen = s_reg.port[p].chen & ~bus_req.wdata[psh_pkg::CH_W-1:0];
				end
				if (hit(bus_off, psh_pkg::OFF_IEN)) begin
					s_next.port[p].imask = s_reg.port[p].imask | bus_req.wdata[psh_pkg::ST_W-1:0];
				end
				if (hit(bus_off, psh_pkg::OFF_IDIS)) begin
					s_next.port[p].imask = s_reg.port[p].imask & ~bus_req.wdata[psh_pkg::ST_W-1:0];
				end
				if (hit(bus_off, psh_pkg::OFF_RX_PTR)) begin
					s_next.port[p].rx_ptr = bus_req.wdata;
				end
				if (hit(bus_off, psh_pkg::OFF_RX_CNT)) begin
					s_next.port[p].rx_cnt = bus_req.wdata[psh_pkg::CNT_W-1:0];
				end
				if (hit(bus_off, psh_pkg::OFF_TX_PTR)) begin
					s_next.port[p].tx_ptr = bus_req.wdata;
				end
				if (hit(bus_off, psh_pkg::OFF_TX_CNT)) begin
					s_next.port[p].tx_cnt = bus_req.wdata[psh_pkg::CNT_W-1:0];
				end
				// Status, channel status and mask offsets take no write
			end

			// Overrun set after the clear so a simultaneous event survives
			if (rx_in_valid[p] && !rx_in_ready[p]) begin
				s_next.port[p].overrun = 1'b1;
			end
		end

		// Read data captured in the setup phase, stable in the access phase
		if (bus_rd) begin
			s_next.rdata = '0;
			for (int p = 0; p < NPORT; p++) begin
				if (32'(bus_port) == p) begin
					unique case (bus_off)
						psh_pkg::OFF_MODE:   s_next.rdata[psh_pkg::MODE_W-1:0] = s_reg.port[p].mode;
						psh_pkg::OFF_CH_ST:  s_next.rdata[psh_pkg::CH_W-1:0]   = s_reg.port[p].chen;
						psh_pkg::OFF_STATUS: s_next.rdata[psh_pkg::ST_W-1:0]   = status[p];
						psh_pkg::OFF_IMASK:  s_next.rdata[psh_pkg::ST_W-1:0]   = s_reg.port[p].imask;
						psh_pkg::OFF_RX_PTR: s_next.rdata = s_reg.port[p].rx_ptr;
						psh_pkg::OFF_RX_CNT: s_next.rdata[psh_pkg::CNT_W-1:0]  = s_reg.port[p].rx_cnt;
						psh_pkg::OFF_TX_PTR: s_next.rdata = s_reg.port[p].tx_ptr;
						psh_pkg::OFF_TX_CNT: s_next.rdata[psh_pkg::CNT_W-1:0]  = s_reg.port[p].tx_cnt;
						// Write-only, enable/disable and unmapped offsets read zero
						default:             s_next.rdata = '0;
					endcase
				end
			end
		end

		if (!rst_n) begin
			s_next.rdata = psh_pkg::RDATA_RST;
			for (int p = 0; p < NPORT; p++) begin
				s_next.port[p].mode    = psh_pkg::MODE_RST;
				s_next.port[p].chen    = psh_pkg::CH_RST;
				s_next.port[p].imask   = psh_pkg::MASK_RST;
				s_next.port[p].overrun = 1'b0;
				s_next.port[p].rx_ptr  = psh_pkg::PTR_RST;
				s_next.port[p].rx_cnt  = psh_pkg::CNT_RST;
				s_next.port[p].tx_ptr  = psh_pkg::PTR_RST;
				s_next.port[p].tx_cnt  = psh_pkg::CNT_RST;
			end
		end
	end

	always_ff @(posedge clock) begin
		s_reg <= s_next;
	end
endmodule : psh_shell

// >>> verification/psh_shell_props.sv
// Concurrent checks on the register shell ports
`timescale 1ns/100ps
module psh_shell_props #(
	parameter int NPORT  = 2,
	parameter int CHAR_W = 8,
	parameter int FIFO_D = 8
) (
	input wire logic                           clock,
	input wire logic                           rst_n,
	input wire psh_pkg::psh_bus_req_t          bus_req,
	input wire logic [psh_pkg::DW-1:0]         bus_rdata,
	input wire logic [NPORT-1:0]               rx_in_valid,
	input wire logic [NPORT-1:0]               rx_in_ready,
	input wire logic [NPORT-1:0][CHAR_W-1:0]   rx_in_data,
	input wire psh_pkg::psh_wr_req_t [NPORT-1:0] rx_wr,
	input wire logic [NPORT-1:0]               rx_wr_ready,
	input wire psh_pkg::psh_rd_req_t [NPORT-1:0] tx_rd,
	input wire logic [NPORT-1:0]               tx_rd_ready,
	input wire logic [NPORT-1:0]               irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire logic bw = bus_req.sel && bus_req.enable && bus_req.write;
	sequence s_rd(logic [13:0] o);
		bus_req.sel && !bus_req.enable && !bus_req.write && !bus_req.addr[14] && bus_req.addr[13:2] == o[13:2];
	endsequence
	sequence s_rx_go;
		rx_wr[0].valid && rx_wr_ready[0] && !bw;
	endsequence
	// Step of one allows fixed-address mode to show no step
	a_rx_ptr_step: assert property (s_rx_go |=> rx_wr[0].addr - $past(rx_wr[0].addr) <= 32'h1)
		else $error("rx pointer step wrong");
	a_tx_ptr_step: assert property (tx_rd[0].valid && tx_rd_ready[0] && !bw |=> tx_rd[0].addr - $past(tx_rd[0].addr) <= 32'h1)
		else $error("tx pointer step wrong");
	a_ctrl_reads_zero: assert property (s_rd(psh_pkg::OFF_CTRL) |=> bus_rdata == 32'h0)
		else $error("command register read not zero");
	a_mask_gates_irq: assert property (s_rd(psh_pkg::OFF_IMASK) ##1 bus_rdata == 32'h0 |-> !irq[0])
		else $error("irq with empty mask");
	a_rx_cnt_idle: assert property (s_rd(psh_pkg::OFF_RX_CNT) ##1 bus_rdata == 32'h0 |-> !rx_wr[0].valid)
		else $error("rx request with zero count");
	a_tx_cnt_idle: assert property (s_rd(psh_pkg::OFF_TX_CNT) ##1 bus_rdata == 32'h0 |-> !tx_rd[0].valid)
		else $error("tx request with zero count");
	a_wr_req_holds: assert property (rx_wr[0].valid && !rx_wr_ready[0] && !bw |=> rx_wr[0].valid && $stable(rx_wr[0].data))
		else $error("rx request dropped");
	a_rdata_stands: assert property (!(bus_req.sel && !bus_req.enable && !bus_req.write) |=> $stable(bus_rdata))
		else $error("read data moved");
endmodule : psh_shell_props
bind psh_shell psh_shell_props #(.NPORT(NPORT), .CHAR_W(CHAR_W), .FIFO_D(FIFO_D)) i_psh_shell_props (
	.clock(clock), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata), .rx_in_valid(rx_in_valid),
	.rx_in_ready(rx_in_ready), .rx_in_data(rx_in_data), .rx_wr(rx_wr), .rx_wr_ready(rx_wr_ready),
	.tx_rd(tx_rd), .tx_rd_ready(tx_rd_ready), .irq(irq));

// >>> verification/psh_mem_model.sv
// Memory side model answering the transfer channels
`timescale 1ns/100ps
module psh_mem_model (
	input wire logic                   clock,
	input wire logic                   slow,
	input wire psh_pkg::psh_wr_req_t [1:0] rx_wr,
	input wire psh_pkg::psh_rd_req_t [1:0] tx_rd,
	output logic [1:0]                 rx_wr_ready,
	output logic [1:0]                 tx_rd_ready
);
	// Random stalls force the channel to hold its request
	always @(posedge clock) begin
		rx_wr_ready <= slow ? 2'($urandom) : 2'h3;
		tx_rd_ready <= slow ? 2'($urandom) : 2'h3;
	end
endmodule : psh_mem_model

// >>> verification/testbench.sv
// Self-checking bench of the register shell
`timescale 1ns/100ps
module testbench;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic slow = 1'b0;
	psh_pkg::psh_bus_req_t bus_req = '0;
	logic [31:0] bus_rdata, r;
	logic [1:0] rx_in_valid = 2'h0;
	logic [1:0][7:0] rx_in_data = '0;
	logic [1:0] rx_in_ready, rx_wr_ready, tx_rd_ready, irq;
	psh_pkg::psh_wr_req_t [1:0] rx_wr;
	psh_pkg::psh_rd_req_t [1:0] tx_rd;
	int bad_count = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [39:0] rx_q[2][$];
	logic [31:0] tx_exp[2];
	int tx_step[2] = '{1, 1};
	int tx_n[2] = '{0, 0};
	always #12.5 clock = ~clock;
	psh_shell i_psh_shell (.clock(clock), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready), .rx_in_data(rx_in_data), .rx_wr(rx_wr),
		.rx_wr_ready(rx_wr_ready), .tx_rd(tx_rd), .tx_rd_ready(tx_rd_ready), .irq(irq));
	psh_mem_model i_psh_mem_model (.clock(clock), .slow(slow), .rx_wr(rx_wr), .tx_rd(tx_rd),
		.rx_wr_ready(rx_wr_ready), .tx_rd_ready(tx_rd_ready));
	task check(input logic [39:0] seen, input logic [39:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task print_verdict();
		$display("Comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	task bus(input bit w, input int p, input logic [13:0] o, input logic [31:0] d);
		@(posedge clock);
		bus_req <= '{sel: 1'b1, enable: 1'b0, write: w, addr: {p[0], o}, wdata: d};
		@(posedge clock);
		bus_req.enable <= 1'b1;
		@(posedge clock);
		r = bus_rdata;
		bus_req <= '0;
	endtask : bus
	task rd(input int p, input logic [13:0] o, input logic [31:0] e);
		bus(1'b0, p, o, 32'h0);
		check(r, e);
	endtask : rd
	task push(input int p, input logic [7:0] d, output bit ok);
		@(posedge clock);
		rx_in_valid[p] <= 1'b1;
		rx_in_data[p] <= d;
		@(posedge clock);
		ok = rx_in_ready[p];
		rx_in_valid[p] <= 1'b0;
	endtask : push
	task wait_q(input int p, input int k);
		for (int i = 0; i < 400 && rx_q[p].size() > k; i++) @(posedge clock);
	endtask : wait_q
	always @(posedge clock) begin
		cycles <= cycles + 1;
		for (int p = 0; p < 2; p++) begin
			if (rst_n && rx_wr[p].valid && rx_wr_ready[p])
				check({rx_wr[p].addr, rx_wr[p].data}, rx_q[p].size() > 0 ? rx_q[p].pop_front() : 40'hFF_FFFF_FFFF);
			if (rst_n && tx_rd[p].valid && tx_rd_ready[p]) begin
				check(tx_rd[p].addr, tx_exp[p]);
				tx_exp[p] += tx_step[p];
				tx_n[p]++;
			end
		end
		if (cycles == 20000) begin
			bad_count++;
			print_verdict();
		end
	end
	initial begin
		bit ok;
		logic [31:0] base;
		logic [7:0] d;
		int n;
		logic [13:0] offs[9] = '{psh_pkg::OFF_CTRL, psh_pkg::OFF_MODE, psh_pkg::OFF_CH_ST, psh_pkg::OFF_IMASK,
			psh_pkg::OFF_RX_PTR, psh_pkg::OFF_RX_CNT, psh_pkg::OFF_TX_PTR, psh_pkg::OFF_TX_CNT, 14'h0100};
		void'($urandom(49));
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		foreach (offs[i]) rd(1, offs[i], 32'h0);
		rd(0, psh_pkg::OFF_STATUS, 32'h3);
		$display("Test reset values done");
		bus(1'b1, 0, psh_pkg::OFF_MODE, 32'hFFFF_FFFF);
		rd(0, psh_pkg::OFF_MODE, 32'h1);
		bus(1'b1, 0, psh_pkg::OFF_MODE + 14'h2, 32'h0);
		rd(0, psh_pkg::OFF_MODE, 32'h0);
		bus(1'b1, 1, psh_pkg::OFF_MODE, 32'h1);
		rd(0, psh_pkg::OFF_MODE, 32'h0);
		bus(1'b1, 1, psh_pkg::OFF_MODE, 32'h0);
		bus(1'b1, 0, psh_pkg::OFF_STATUS, 32'h0);
		rd(0, psh_pkg::OFF_STATUS, 32'h3);
		bus(1'b1, 0, psh_pkg::OFF_CH_SET, 32'h3);
		bus(1'b1, 0, psh_pkg::OFF_CH_CLR, 32'h1);
		rd(0, psh_pkg::OFF_CH_ST, 32'h2);
		bus(1'b1, 0, psh_pkg::OFF_CH_CLR, 32'h2);
		bus(1'b1, 0, psh_pkg::OFF_IEN, 32'h1);
		rd(0, psh_pkg::OFF_IMASK, 32'h1);
		check(irq, 2'h1);
		bus(1'b1, 0, psh_pkg::OFF_IDIS, 32'h1);
		// Mask lands on the write edge, so look once it has settled
		rd(0, psh_pkg::OFF_IMASK, 32'h0);
		check(irq, 2'h0);
		$display("Test registers done");
		slow <= 1'b1;
		for (int p = 0; p < 2; p++) begin
			base = $urandom;
			n = 0;
			bus(1'b1, p, psh_pkg::OFF_RX_PTR, base);
			bus(1'b1, p, psh_pkg::OFF_RX_CNT, 32'h5);
			bus(1'b1, p, psh_pkg::OFF_CH_SET, 32'h1);
			for (int i = 0; i < 14; i++) begin
				d = $urandom;
				push(p, d, ok);
				if (ok) rx_q[p].push_back({base + n, d});
				if (ok) n++;
				if (i == 7) wait_q(p, 3);
				if (i == 7) rd(p, psh_pkg::OFF_RX_CNT, 32'h0);
			end
			check(n, 13);
			rd(p, psh_pkg::OFF_STATUS, 32'hF);
			bus(1'b1, p, psh_pkg::OFF_CTRL, 32'h1);
			rd(p, psh_pkg::OFF_STATUS, 32'h7);
			bus(1'b1, p, psh_pkg::OFF_RX_CNT, 32'h8);
			wait_q(p, 0);
			rd(p, psh_pkg::OFF_RX_PTR, base + 32'd13);
			rd(p, psh_pkg::OFF_STATUS, 32'h3);
			bus(1'b1, p, psh_pkg::OFF_CH_CLR, 32'h1);
			base = $urandom;
			tx_exp[p] = base;
			bus(1'b1, p, psh_pkg::OFF_TX_PTR, base);
			bus(1'b1, p, psh_pkg::OFF_TX_CNT, 32'h3);
			bus(1'b1, p, psh_pkg::OFF_CH_SET, 32'h2);
			for (int i = 0; i < 200 && tx_n[p] != 3; i++) @(posedge clock);
			rd(p, psh_pkg::OFF_TX_CNT, 32'h0);
			rd(p, psh_pkg::OFF_TX_PTR, base + 32'd3);
			$display("Test channels of port %0d done", p);
		end
		// Fixed-address mode: fetches repeat one address
		bus(1'b1, 0, psh_pkg::OFF_MODE, 32'h1);
		base = $urandom;
		tx_exp[0] = base;
		tx_step[0] = 0;
		tx_n[0] = 0;
		bus(1'b1, 0, psh_pkg::OFF_TX_PTR, base);
		bus(1'b1, 0, psh_pkg::OFF_TX_CNT, 32'h2);
		for (int i = 0; i < 200 && tx_n[0] != 2; i++) @(posedge clock);
		rd(0, psh_pkg::OFF_TX_PTR, base);
		rd(0, psh_pkg::OFF_TX_CNT, 32'h0);
		$display("Test fixed address done");
		// Second reset after activity must restore mode, channel enables and the rx pointer
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		rd(0, psh_pkg::OFF_MODE, 32'h0);
		rd(0, psh_pkg::OFF_CH_ST, 32'h0);
		rd(1, psh_pkg::OFF_RX_PTR, 32'h0);
		check(irq, 2'h0);
		$display("Test second reset done");
		print_verdict();
	end
endmodule : testbench
